/* File: tb/msfs_host_model.sv */
`default_nettype none
// host side master: drives serial clock, select and data in
module msfs_host_model (
    input wire logic clk,
    input wire logic serial_out_pin,
    output var logic serial_clk,
    output var logic port_select_n,
    output var logic serial_in_line
);
    timeunit 1ns;
    timeprecision 1ps;
    int half = 10; // clk cycles per serial half period, bench may slow it
    // idle pins: clock low, deselected
    initial begin
        serial_clk = 1'b0;
        port_select_n = 1'b1;
        serial_in_line = 1'b1;
    end
    // select falls with the clock idling low
    task automatic open_frame();
        @(negedge clk);
        port_select_n <= 1'b0;
        repeat (half) @(negedge clk);
    endtask
    // one byte each way, msb first
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            serial_clk <= 1'b1;
            serial_in_line <= tx[i];
            repeat (half) @(negedge clk);
            rx[i] = serial_out_pin;
            serial_clk <= 1'b0;
            repeat (half) @(negedge clk);
        end
    endtask
    // select rises, then the released data line flips so no stale bit stays
    task automatic close_frame();
        port_select_n <= 1'b1;
        repeat (half) @(negedge clk);
        serial_in_line <= ~serial_in_line;
        repeat (half) @(negedge clk);
    endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WB = 3;
    localparam int W = 8 * WB;
    // write enable command: register and code are arbitrary stand-ins
    localparam logic [10:0] WREN_ADDR = 11'h150;
    localparam logic [W-1:0] WREN_CODE = 24'h0000e5;
    logic clk, reset;
    wire logic serial_clk, port_select_n, serial_in_line, serial_out_pin;
    logic serial_out_line, serial_out_oe, reg_rd_req, reg_wr_req, csum_error;
    logic [10:0] reg_addr, wr_addr;
    logic [W-1:0] reg_rd_data, reg_wr_data, read_check, write_check;
    logic [W-1:0] wr_data, last_rd, last_wr;
    logic [10:0] addr_q[$];
    int failures = 0, n_tests = 0, n_wr = 0, n_err = 0;
    // output pin floats while the device lets go
    assign serial_out_pin = serial_out_oe ? serial_out_line : 1'bz;

    msfs_spi_slave #(
        .WORD_BYTES(WB)
    ) msfs_spi_slave_inst (
        .clk(clk),
        .reset(reset),
        .serial_clk(serial_clk),
        .port_select_n(port_select_n),
        .serial_in_line(serial_in_line),
        .serial_out_line(serial_out_line),
        .serial_out_oe(serial_out_oe),
        .reg_addr(reg_addr),
        .reg_rd_req(reg_rd_req),
        .reg_rd_data(reg_rd_data),
        .reg_wr_req(reg_wr_req),
        .reg_wr_data(reg_wr_data),
        .csum_error(csum_error),
        .read_check(read_check),
        .write_check(write_check)
    );

    msfs_host_model msfs_host_model_inst (
        .clk(clk),
        .serial_out_pin(serial_out_pin),
        .serial_clk(serial_clk),
        .port_select_n(port_select_n),
        .serial_in_line(serial_in_line)
    );

    // 50 MHz system clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // word the user side holds at an address
    function automatic logic [W-1:0] word_at(input logic [10:0] a);
        return {a[7:0], 5'h0a, a[10:8], a[7:0] ^ 8'h3c};
    endfunction

    // user side: answers a fetch within one cycle, logs every request
    always @(negedge clk) begin
        if (reg_rd_req) begin
            reg_rd_data <= word_at(reg_addr);
            addr_q.push_back(reg_addr);
        end
        if (reg_wr_req) begin
            wr_addr = reg_addr;
            wr_data = reg_wr_data;
            n_wr++;
        end
        if (csum_error) begin
            n_err++;
        end
    end

    // the one compare task; unknown bits never pass
    task automatic check(input logic [31:0] got, exp, input string what);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // read frame of n words from a; the first word is expected as w0
    task automatic do_read(input logic [10:0] a, input logic [1:0] bl,
                           input int n, input logic [W-1:0] w0);
        logic [7:0] cmd, r, s;
        logic [W-1:0] w;
        int q0;
        cmd = {1'b0, a[10:8], bl, 2'h0};
        s = a[7:0] + cmd;
        q0 = addr_q.size();
        w = w0;
        msfs_host_model_inst.open_frame();
        msfs_host_model_inst.xfer(a[7:0], r);
        msfs_host_model_inst.xfer(cmd, r);
        for (int i = 0; i < n; i++) begin
            w = (i == 0) ? w0 : word_at(a + 11'(i));
            for (int k = WB - 1; k >= 0; k--) begin
                msfs_host_model_inst.xfer(8'h00, r);
                check(r, w[8*k +: 8], "read data byte");
                s = s + w[8*k +: 8];
            end
            check(addr_q[q0 + i], a + 11'(i), "fetch address");
        end
        msfs_host_model_inst.xfer(8'h00, r);
        check(r, 8'(~s), "read checksum");
        msfs_host_model_inst.close_frame();
        check(serial_out_oe, 1'b0, "output released");
        check(addr_q.size(), q0 + n, "fetch count");
        check(read_check, w, "read-check word");
        last_rd = w;
    endtask

    // write frame of one word; bad is xored into the checksum byte
    task automatic do_write(input logic [10:0] a, input logic [W-1:0] d,
                            input logic [1:0] bl, input logic [7:0] bad);
        logic [7:0] cmd, r, s;
        cmd = {1'b1, a[10:8], bl, 2'h0};
        s = a[7:0] + cmd;
        msfs_host_model_inst.open_frame();
        msfs_host_model_inst.xfer(a[7:0], r);
        msfs_host_model_inst.xfer(cmd, r);
        for (int k = WB - 1; k >= 0; k--) begin
            msfs_host_model_inst.xfer(d[8*k +: 8], r);
            s = s + d[8*k +: 8];
        end
        msfs_host_model_inst.xfer(~s ^ bad, r);
        msfs_host_model_inst.close_frame();
    endtask

    // single reads of plain banks: burst field must be ignored
    task automatic t_plain_read();
        do_read(11'h0a5, 2'h3, 1, word_at(11'h0a5));
        do_read(11'h1f0, 2'h2, 1, word_at(11'h1f0));
        do_read(11'h5a0, 2'h3, 1, word_at(11'h5a0));
    endtask

    // buffer bursts, each length code once
    task automatic t_burst_read();
        do_read(11'h27c, 2'h3, 16, word_at(11'h27c));
        do_read(11'h3f8, 2'h2, 8, word_at(11'h3f8));
        do_read(11'h4fc, 2'h1, 4, word_at(11'h4fc));
        do_read(11'h480, 2'h0, 1, word_at(11'h480));
    endtask

    // write enable first, then a good and a corrupted write
    task automatic t_write();
        int w0, e0;
        w0 = n_wr;
        e0 = n_err;
        do_write(WREN_ADDR, WREN_CODE, 2'h0, 8'h00);
        do_write(11'h1c4, 24'h12a5f0, 2'h2, 8'h00);
        check(n_wr, w0 + 2, "writes taken");
        check(wr_addr, 11'h1c4, "write address");
        check(wr_data, 24'h12a5f0, "write data");
        check(write_check, 24'h12a5f0, "write-check word");
        do_write(11'h1c8, 24'h00ff00, 2'h0, 8'h01);
        check(n_wr, w0 + 2, "bad write taken");
        check(n_err, e0 + 1, "checksum error pulses");
        check(write_check, 24'h12a5f0, "write-check after bad");
        last_wr = 24'h12a5f0;
    endtask

    // check words are answered by the port itself
    task automatic t_check_regs();
        do_read(11'h08d, 2'h0, 1, last_wr);
        do_read(11'h08c, 2'h0, 1, last_rd);
    endtask

    // select raised in mid read: output released, next frame answered
    task automatic t_abort();
        logic [7:0] r;
        msfs_host_model_inst.open_frame();
        msfs_host_model_inst.xfer(8'h33, r);
        msfs_host_model_inst.xfer(8'h00, r);
        msfs_host_model_inst.xfer(8'h00, r);
        check(serial_out_oe, 1'b1, "output during read");
        msfs_host_model_inst.close_frame();
        check(serial_out_oe, 1'b0, "output after abort");
        do_read(11'h033, 2'h0, 1, word_at(11'h033));
    endtask

    // reset in mid run clears the check words; first frame still works
    task automatic t_mid_reset();
        @(negedge clk);
        reset = 1'b1;
        repeat (12) @(negedge clk);
        reset = 1'b0;
        check(read_check, 32'h0, "read-check after reset");
        check(write_check, 32'h0, "write-check after reset");
        do_read(11'h08d, 2'h0, 1, '0);
    endtask

    // counts, verdict and end of run
    task automatic test_done();
        $display("checks %0d failures %0d writes %0d bad sums %0d",
                 n_tests, failures, n_wr, n_err);
        if (failures == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // watchdog: the scenarios need about 26000 clocks
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        $display("MISMATCH %0t watchdog expired", $time);
        test_done();
    end

    // reset, scenarios, verdict
    initial begin
        reset = 1'b1;
        repeat (12) @(negedge clk);
        reset = 1'b0;
        check(serial_out_oe, 1'b0, "output after reset");
        t_plain_read();
        t_burst_read();
        t_write();
        t_check_regs();
        t_abort();
        t_mid_reset();
        test_done();
    end
endmodule
`default_nettype wire

/* File: verilog/msfs_pkg.sv */
`default_nettype none
package msfs_pkg;
    // address space
    localparam int ADDR_W = 11;
    localparam logic [2:0] BANK_MEAS = 3'h0;
    localparam logic [2:0] BANK_CFG = 3'h1;
    localparam logic [2:0] BANK_WAVE_LO = 3'h2;
    localparam logic [2:0] BANK_WAVE_HI = 3'h4;
    localparam logic [10:0] WAVE_FIRST = 11'h200;
    localparam logic [10:0] WAVE_LAST = 11'h4ff;
    localparam logic [10:0] READ_CHECK_ADDR = 11'h08c;
    localparam logic [10:0] WRITE_CHECK_ADDR = 11'h08d;
    // command byte fields
    localparam int CMD_DIR_BIT = 7;
    localparam int CMD_BANK_LSB = 4;
    localparam int CMD_BL_LSB = 2;
    localparam logic CMD_DIR_WRITE = 1'b1;
    // burst lengths in words
    localparam logic [4:0] BURST_1 = 5'h01;
    localparam logic [4:0] BURST_4 = 5'h04;
    localparam logic [4:0] BURST_8 = 5'h08;
    localparam logic [4:0] BURST_16 = 5'h10;
    // bits per byte and last bit index
    localparam int BYTE_W = 8;
    localparam logic [2:0] LAST_BIT = 3'h7;
    // read data arrives one cycle after the request pulse
    localparam int READ_LATENCY = 1;
endpackage
`default_nettype wire

/* File: verilog/msfs_spi_slave.sv */
`default_nettype none
// Overview of operation
// - slave only; host drives serial clock and select
// - 11-bit address; 0x000-0x0ff measurement, 0x100-0x1ff configuration
// - six 128-address waveform buffer blocks, 0x200 up to 0x4ff
// - select falling opens a frame; rising returns port to idle
// - outgoing bits launched on rising clock, incoming sampled on falling
// - serial output released whenever select is high
// - command byte: direction, three bank bits, burst field, two zeros
// - burst field 00/01/10/11 means 1/4/8/16 addresses read
// - waveform reads honour burst length and increment address per word
// - burst field unused for writes and other reads, still summed
// - whole bytes msb first; words most significant byte first
// - on reads device sends inverted sum as last byte
// - checksum is inverted 8-bit sum of address, command, data
// - bank 0 measurement, 1 configuration, 2 to 4 waveform buffer
// - read-check word at 0x8c holds last word read
// - write-check word at 0x8d holds last word written
module msfs_spi_slave #(
    parameter int WORD_BYTES = 3
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic serial_clk,
    input wire logic port_select_n,
    input wire logic serial_in_line,
    output logic serial_out_line,
    output logic serial_out_oe,
    output logic [10:0] reg_addr,
    output logic reg_rd_req,
    input wire logic [8*WORD_BYTES-1:0] reg_rd_data,
    output logic reg_wr_req,
    output logic [8*WORD_BYTES-1:0] reg_wr_data,
    output logic csum_error,
    output logic [8*WORD_BYTES-1:0] read_check,
    output logic [8*WORD_BYTES-1:0] write_check
);
    localparam int W = 8 * WORD_BYTES;

    if (WORD_BYTES < 1 || WORD_BYTES > 4) begin : g_chk
        $error("WORD_BYTES must be 1 to 4");
    end

    typedef enum logic [2:0] {
        MSFS_IDLE, MSFS_ADDR, MSFS_CMD, MSFS_WR_DATA,
        MSFS_WR_SUM, MSFS_RD_DATA, MSFS_RD_SUM, MSFS_DONE
    } msfs_state_t;

    // synchronisers for the host pins; only stage two onward is read
    logic sclk_s1, sclk_s2, sclk_s3;
    logic csn_s1, csn_s2, csn_s3;
    logic sdi_s1, sdi_s2;

    // host pins only sampled, device never drives the clock
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
            csn_s1 <= 1'b1;
            csn_s2 <= 1'b1;
            csn_s3 <= 1'b1;
            sdi_s1 <= 1'b0;
            sdi_s2 <= 1'b0;
        end else begin
            sclk_s1 <= serial_clk;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            csn_s1 <= port_select_n;
            csn_s2 <= csn_s1;
            csn_s3 <= csn_s2;
            sdi_s1 <= serial_in_line;
            sdi_s2 <= sdi_s1;
        end
    end

    // edge events of the synchronised pins
    logic rise, fall, sel_fall, sel_rise;
    assign rise = sclk_s2 & ~sclk_s3;
    assign fall = ~sclk_s2 & sclk_s3;
    assign sel_fall = ~csn_s2 & csn_s3;
    assign sel_rise = csn_s2 & ~csn_s3;

    msfs_state_t state, next_state;
    logic [2:0] bit_cnt, next_bit_cnt;
    logic [1:0] byte_cnt, next_byte_cnt;
    logic [4:0] words_left, next_words_left;
    logic [7:0] rx_sh, next_rx_sh;
    logic [7:0] tx_sh, next_tx_sh;
    logic [7:0] sum, next_sum;
    logic [10:0] next_reg_addr;
    logic [W-1:0] word, next_word;
    logic [W-1:0] next_reg_wr_data;
    logic [1:0] ld, next_ld;
    logic next_sout, next_oe, next_rd_req, next_wr_req, next_cerr;
    logic [W-1:0] next_rchk, next_wchk;

    // byte completed on this falling edge, and its value
    logic byte_end;
    logic [7:0] rx_byte;
    logic [W+7:0] wr_shift;
    logic [W-1:0] rd_src;
    logic [2:0] cmd_bank;
    logic [4:0] cmd_burst;
    logic last_byte;
    assign byte_end = fall && (bit_cnt == msfs_pkg::LAST_BIT);
    assign rx_byte = {rx_sh[6:0], sdi_s2};
    assign wr_shift = {reg_wr_data, rx_byte};
    assign last_byte = (byte_cnt == 2'(WORD_BYTES - 1));
    assign cmd_bank = rx_byte[msfs_pkg::CMD_BANK_LSB +: 3];

    // byte idx of a word, most significant first
    function automatic logic [7:0] byte_of(input logic [W-1:0] w,
                                           input logic [1:0] idx);
        int sh;
        sh = (WORD_BYTES - 1 - int'(idx)) * msfs_pkg::BYTE_W;
        return 8'(w >> sh);
    endfunction

    // burst length only for waveform banks
    always_comb begin
        cmd_burst = msfs_pkg::BURST_1;
        if (cmd_bank >= msfs_pkg::BANK_WAVE_LO &&
            cmd_bank <= msfs_pkg::BANK_WAVE_HI) begin
            case (rx_byte[msfs_pkg::CMD_BL_LSB +: 2])
                2'h0: cmd_burst = msfs_pkg::BURST_1;
                2'h1: cmd_burst = msfs_pkg::BURST_4;
                2'h2: cmd_burst = msfs_pkg::BURST_8;
                default: cmd_burst = msfs_pkg::BURST_16;
            endcase
        end
    end

    // read source, check words answered locally
    always_comb begin
        if (reg_addr == msfs_pkg::READ_CHECK_ADDR) begin
            rd_src = read_check;
        end else if (reg_addr == msfs_pkg::WRITE_CHECK_ADDR) begin
            rd_src = write_check;
        end else begin
            rd_src = reg_rd_data;
        end
    end

    // frame sequencer next values
    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_byte_cnt = byte_cnt;
        next_words_left = words_left;
        next_rx_sh = rx_sh;
        next_tx_sh = tx_sh;
        next_sum = sum;
        next_reg_addr = reg_addr;
        next_word = word;
        next_reg_wr_data = reg_wr_data;
        next_ld = {ld[0], 1'b0};
        next_sout = serial_out_line;
        next_oe = serial_out_oe;
        next_rd_req = 1'b0;
        next_wr_req = 1'b0;
        next_cerr = 1'b0;
        next_rchk = read_check;
        next_wchk = write_check;
        if (csn_s2) begin
            next_state = MSFS_IDLE;
            next_oe = 1'b0;
            next_ld = 2'h0;
        end else if (sel_fall) begin
            next_state = MSFS_ADDR;
            next_bit_cnt = 3'h0;
            next_byte_cnt = 2'h0;
            next_sum = 8'h00;
        end else begin
            // sample on falling edge
            if (fall) begin
                next_rx_sh = rx_byte;
                next_bit_cnt = bit_cnt + 3'h1;
            end
            // launch on rising edge
            if (rise && serial_out_oe) begin
                next_sout = tx_sh[7];
                next_tx_sh = {tx_sh[6:0], 1'b0};
            end
            // fetched word arrives, first byte staged
            if (ld[1]) begin
                next_word = rd_src;
                next_rchk = rd_src;
                next_tx_sh = byte_of(rd_src, 2'h0);
                next_sum = sum + byte_of(rd_src, 2'h0);
            end
            case (state)
                MSFS_IDLE: begin
                end
                MSFS_ADDR: begin
                    if (byte_end) begin
                        next_reg_addr[7:0] = rx_byte;
                        next_sum = sum + rx_byte;
                        next_state = MSFS_CMD;
                    end
                end
                MSFS_CMD: begin
                    if (byte_end) begin
                        next_reg_addr[10:8] = cmd_bank;
                        next_sum = sum + rx_byte;
                        next_words_left = cmd_burst;
                        next_byte_cnt = 2'h0;
                        if (rx_byte[msfs_pkg::CMD_DIR_BIT] ==
                            msfs_pkg::CMD_DIR_WRITE) begin
                            next_state = MSFS_WR_DATA;
                        end else begin
                            next_state = MSFS_RD_DATA;
                            next_rd_req = 1'b1;
                            next_ld = {ld[0], 1'b1};
                            next_oe = 1'b1;
                        end
                    end
                end
                MSFS_WR_DATA: begin
                    if (byte_end) begin
                        next_reg_wr_data = wr_shift[W-1:0];
                        next_sum = sum + rx_byte;
                        next_byte_cnt = byte_cnt + 2'h1;
                        if (last_byte) begin
                            next_state = MSFS_WR_SUM;
                        end
                    end
                end
                MSFS_WR_SUM: begin
                    if (byte_end) begin
                        next_state = MSFS_DONE;
                        if (rx_byte == ~sum) begin
                            next_wr_req = 1'b1;
                            next_wchk = reg_wr_data;
                        end else begin
                            next_cerr = 1'b1;
                        end
                    end
                end
                MSFS_RD_DATA: begin
                    if (byte_end) begin
                        next_byte_cnt = 2'h0;
                        if (!last_byte) begin
                            next_byte_cnt = byte_cnt + 2'h1;
                            next_tx_sh = byte_of(word, byte_cnt + 2'h1);
                            next_sum = sum + next_tx_sh;
                        end else if (words_left == 5'h01) begin
                            next_state = MSFS_RD_SUM;
                            next_tx_sh = ~sum;
                        end else begin
                            next_words_left = words_left - 5'h01;
                            next_reg_addr = reg_addr + 11'h001;
                            next_rd_req = 1'b1;
                            next_ld = {ld[0], 1'b1};
                        end
                    end
                end
                MSFS_RD_SUM: begin
                    if (byte_end) begin
                        next_state = MSFS_DONE;
                        next_oe = 1'b0;
                    end
                end
                MSFS_DONE: begin
                end
                default: next_state = MSFS_IDLE;
            endcase
        end
    end

    // frame sequencer registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= MSFS_IDLE;
            bit_cnt <= 3'h0;
            byte_cnt <= 2'h0;
            words_left <= 5'h00;
            rx_sh <= 8'h00;
            tx_sh <= 8'h00;
            sum <= 8'h00;
            reg_addr <= 11'h000;
            word <= '0;
            reg_wr_data <= '0;
            ld <= 2'h0;
            serial_out_line <= 1'b0;
            serial_out_oe <= 1'b0;
            reg_rd_req <= 1'b0;
            reg_wr_req <= 1'b0;
            csum_error <= 1'b0;
            read_check <= '0;
            write_check <= '0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            byte_cnt <= next_byte_cnt;
            words_left <= next_words_left;
            rx_sh <= next_rx_sh;
            tx_sh <= next_tx_sh;
            sum <= next_sum;
            reg_addr <= next_reg_addr;
            word <= next_word;
            reg_wr_data <= next_reg_wr_data;
            ld <= next_ld;
            serial_out_line <= next_sout;
            serial_out_oe <= next_oe;
            reg_rd_req <= next_rd_req;
            reg_wr_req <= next_wr_req;
            csum_error <= next_cerr;
            read_check <= next_rchk;
            write_check <= next_wchk;
        end
    end

    // checks on the sequencer
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_cmd_read;
        state == MSFS_CMD && byte_end && !rx_byte[7];
    endsequence
    sequence s_word_end;
        state == MSFS_RD_DATA && byte_end && last_byte;
    endsequence

    a_oe_off_deselect: assert property (
        csn_s2 |=> !serial_out_oe)
        else $error("output driven while deselected");
    a_idle_on_release: assert property (
        sel_rise |=> state == MSFS_IDLE)
        else $error("port not idle after release");
    a_launch_on_rise: assert property (
        !$stable(serial_out_line) |-> $past(rise))
        else $error("output bit changed off a rising edge");
    a_addr_low_byte: assert property (
        state == MSFS_ADDR && byte_end
        |=> reg_addr[7:0] == $past(rx_byte))
        else $error("low address byte not captured");
    a_read_fetch: assert property (
        s_cmd_read |=> reg_rd_req ##2 ld == 2'h0)
        else $error("read fetch not issued");
    a_wave_burst_len: assert property (
        s_cmd_read ##0 cmd_bank == msfs_pkg::BANK_WAVE_LO
        ##0 rx_byte[3:2] == 2'h3 |=> words_left == 5'h10)
        else $error("burst of sixteen not loaded");
    a_plain_single: assert property (
        s_cmd_read ##0 cmd_bank == msfs_pkg::BANK_MEAS
        |=> words_left == 5'h01)
        else $error("burst field used outside buffer");
    a_burst_incr: assert property (
        s_word_end ##0 words_left > 5'h01
        |=> reg_addr == $past(reg_addr) + 11'h001 && reg_rd_req)
        else $error("burst address not incremented");
    a_read_sum_byte: assert property (
        s_word_end ##0 words_left == 5'h01
        |=> tx_sh == ~$past(sum) && state == MSFS_RD_SUM)
        else $error("checksum byte not staged");
    a_wr_good_sum: assert property (
        reg_wr_req |-> $past(rx_byte) == ~$past(sum)
        && write_check == reg_wr_data)
        else $error("write taken with bad checksum");
    a_read_check: assert property (
        ld[1] |=> read_check == word)
        else $error("read-check word not captured");
endmodule
`default_nettype wire
